// *** src/mmb_bus_ctrl.sv ***
// minimum-mode bus state sequencer with transceiver control and bus hold handshake
`timescale 1ns/100ps
// What this block does
// - transfer direction high while transmitting data, low while receiving.
// - direction timed like select; equals inverted maximum-mode status line one.
// - direction released to high impedance, held one, while bus granted.
// - transceiver enable asserted low for memory, IO and interrupt acknowledge cycles.
// - read and acknowledge cycles: enable from mid T2 until mid T4.
// - write cycles: enable from start of T2 until mid T4.
// - transceiver enable released, held one, while bus granted.
// - grant raised high at middle of T4 or of an idle state on request.
// - local bus and control outputs float together with raising grant.
// - grant dropped after bus request sampled low.
// - after grant drops, bus driven again only when next cycle runs.
// - bus request sampled on clock, with no internal synchroniser.
// - low status output equals inverted maximum-mode status line zero.
// - select valid from T4 or setup state before cycle to final T4; high is IO.
// - select, direction, low status encode acknowledge, IO read, IO write.
// - low status released, held one, while bus granted.
module mmb_bus_ctrl
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // cycle requests from the execution side
   input wire mmb_pkg::mmb_req_t cycReq,
   output logic cycReqReady,
   input wire logic waitReady,
   output logic cycDone,
   // hold handshake with another master
   input wire logic busReq,
   output logic busGrantOut,
   output logic busFloat,
   // transceiver and status pins, each with an active-low output enable
   output logic transferDirection,
   output logic transferDirectionOeN,
   output logic transceiverEnableN,
   output logic transceiverEnableOeN,
   output logic cycleStatusLow,
   output logic cycleStatusLowOeN,
   output logic ioMemSel,
   output logic ioMemSelOeN
);

   // ****************************************************************
   // clock states
   // ****************************************************************
   typedef enum logic [2:0]
   {
      ST_IDLE,
      ST_SETUP,
      ST_T1,
      ST_T2,
      ST_T3,
      ST_TW,
      ST_T4,
      ST_HOLD
   } mmb_state_t;

   mmb_state_t stReg;
   mmb_state_t stNext;
   logic phReg;
   logic phNext;
   logic [mmb_pkg::HALF_CNT_W-1:0] halfCntReg;
   logic [mmb_pkg::HALF_CNT_W-1:0] halfCntNext;
   logic reqSmpReg;
   logic grantReg;
   logic grantNext;
   logic floatReg;
   logic floatNext;
   mmb_pkg::mmb_status_t statReg;
   mmb_pkg::mmb_status_t statNext;
   mmb_pkg::mmb_cycle_t kindReg;
   mmb_pkg::mmb_cycle_t kindNext;
   logic enNReg;
   logic enNNext;
   logic doneReg;

   // ****************************************************************
   // phase timing and decision points
   // ****************************************************************
   wire halfEnd = (halfCntReg == mmb_pkg::HALF_LAST);
   // end of the first half: the middle of a clock state
   wire atMid = halfEnd && !phReg;
   // end of the second half: the boundary into the next clock state
   wire atEnd = halfEnd && phReg;
   // request sampled on the clock, no extra stages
   wire holdWanted = reqSmpReg;
   wire inT4 = (stReg == ST_T4) ? 1'b1 : 1'b0;

   // ****************************************************************
   // cycle decode
   // ****************************************************************
   // writes open the enable half a state before reads and acknowledges,
   // so the kind of the running cycle is kept beside its status
   wire curIsWrite = (kindReg == mmb_pkg::MMB_IO_WRITE) ||
                     (kindReg == mmb_pkg::MMB_MEM_WRITE);
   mmb_pkg::mmb_status_t reqStat;

   always_comb
   begin
      unique case (cycReq.kind)
         mmb_pkg::MMB_INT_ACK: reqStat = mmb_pkg::STAT_INT_ACK;
         mmb_pkg::MMB_IO_READ: reqStat = mmb_pkg::STAT_IO_READ;
         mmb_pkg::MMB_IO_WRITE: reqStat = mmb_pkg::STAT_IO_WRITE;
         mmb_pkg::MMB_CODE_READ: reqStat = mmb_pkg::STAT_CODE_READ;
         mmb_pkg::MMB_MEM_READ: reqStat = mmb_pkg::STAT_MEM_READ;
         mmb_pkg::MMB_MEM_WRITE: reqStat = mmb_pkg::STAT_MEM_WRITE;
         default: reqStat = mmb_pkg::STAT_RST;
      endcase
   end

   // a new cycle is taken at the end of T3/TW going into T4, or at the end of idle
   wire enteringT4 = atEnd && waitReady &&
                     ((stReg == ST_T3) || (stReg == ST_TW));
   wire takeBackToBack = enteringT4 && cycReq.valid && !holdWanted;
   wire takeFromIdle = atEnd && (stReg == ST_IDLE) && cycReq.valid && !holdWanted;
   wire takeCycle = takeBackToBack || takeFromIdle;
   logic pendReg;
   logic pendNext;

   // grant in the middle of T4 with nothing pending, or in the middle of an idle state
   wire grantAtT4 = atMid && inT4 && holdWanted && !pendReg;
   wire grantAtIdle = atMid && (stReg == ST_IDLE) && holdWanted;
   wire grantNow = grantAtT4 || grantAtIdle;
   wire releaseNow = atEnd && (stReg == ST_HOLD) && !holdWanted;

   assign cycReqReady = takeCycle;

   // ****************************************************************
   // state sequencing
   // ****************************************************************
   always_comb
   begin
      stNext = stReg;
      unique case (stReg)
         ST_IDLE:
            if (grantNow)
               stNext = ST_HOLD;
            else if (takeFromIdle)
               stNext = ST_SETUP;
         ST_SETUP:
            if (atEnd)
               stNext = ST_T1;
         ST_T1:
            if (atEnd)
               stNext = ST_T2;
         ST_T2:
            if (atEnd)
               stNext = ST_T3;
         ST_T3, ST_TW:
            if (atEnd)
               stNext = waitReady ? ST_T4 : ST_TW;
         ST_T4:
            if (grantNow)
               stNext = ST_HOLD;
            else if (atEnd)
               stNext = pendReg ? ST_T1 : ST_IDLE;
         ST_HOLD:
            if (releaseNow)
               stNext = ST_IDLE;
      endcase
   end

   // hold entered at mid state restarts at the second half
   always_comb
   begin
      halfCntNext = halfEnd ? mmb_pkg::HALF_CNT_RST : halfCntReg + 4'h1;
      phNext = halfEnd ? !phReg : phReg;
   end

   always_comb
   begin
      pendNext = pendReg;
      if (takeBackToBack)
         pendNext = 1'b1;
      else if (atEnd && inT4)
         pendNext = 1'b0;
   end

   // ****************************************************************
   // status, grant and float
   // ****************************************************************
   // status loads as the preceding T4 or setup state begins and holds until the next cycle is taken
   always_comb
   begin
      statNext = statReg;
      kindNext = kindReg;
      if (takeCycle)
      begin
         statNext = reqStat;
         kindNext = cycReq.kind;
      end
   end

   always_comb
   begin
      grantNext = grantReg;
      floatNext = floatReg;
      if (grantNow)
      begin
         grantNext = 1'b1;
         floatNext = 1'b1;
      end
      else if (releaseNow)
         grantNext = 1'b0;
      else if (takeCycle)
         floatNext = 1'b0;
   end

   // ****************************************************************
   // transceiver enable windows
   // ****************************************************************
   wire nextT2First = (stNext == ST_T2) && !phNext;
   wire nextT2Second = (stNext == ST_T2) && phNext;
   wire nextMidCycle = (stNext == ST_T3) || (stNext == ST_TW);
   wire nextT4First = (stNext == ST_T4) && !phNext;
   // read and acknowledge: mid T2 to mid T4
   wire readWin = nextT2Second || nextMidCycle || nextT4First;
   // write: start of T2 to mid T4
   wire writeWin = nextT2First || readWin;
   // every access kind opens a window, idle and hold keep it closed
   wire winOpen = curIsWrite ? writeWin : readWin;

   always_comb
   begin
      enNNext = winOpen ? mmb_pkg::XCVR_EN_ON : mmb_pkg::XCVR_EN_OFF;
   end

   // ****************************************************************
   // registers
   // ****************************************************************
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         stReg <= ST_IDLE;
         phReg <= 1'b0;
         halfCntReg <= mmb_pkg::HALF_CNT_RST;
         reqSmpReg <= 1'b0;
         pendReg <= 1'b0;
      end
      else
      begin
         stReg <= stNext;
         phReg <= phNext;
         halfCntReg <= halfCntNext;
         reqSmpReg <= busReq;
         pendReg <= pendNext;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         grantReg <= mmb_pkg::GRANT_RST;
         floatReg <= mmb_pkg::FLOAT_RST;
         statReg <= mmb_pkg::STAT_RST;
         kindReg <= mmb_pkg::MMB_CODE_READ;
         enNReg <= mmb_pkg::XCVR_EN_OFF;
         doneReg <= 1'b0;
      end
      else
      begin
         grantReg <= grantNext;
         floatReg <= floatNext;
         statReg <= statNext;
         kindReg <= kindNext;
         enNReg <= enNNext;
         doneReg <= enteringT4;
      end
   end

   // ****************************************************************
   // pin drive
   // ****************************************************************
   assign busGrantOut = grantReg;
   assign busFloat = floatReg;
   assign cycDone = doneReg;

   // direction equals inverted status line one, same timing as the select
   assign transferDirection = floatReg ? mmb_pkg::PIN_HOLD_LEVEL :
                              statReg.transferDirection;
   assign transferDirectionOeN = floatReg ? mmb_pkg::OE_RELEASE : mmb_pkg::OE_DRIVE;

   assign transceiverEnableN = floatReg ? mmb_pkg::PIN_HOLD_LEVEL : enNReg;
   assign transceiverEnableOeN = floatReg ? mmb_pkg::OE_RELEASE : mmb_pkg::OE_DRIVE;

   // low status equals inverted status line zero
   assign cycleStatusLow = floatReg ? mmb_pkg::PIN_HOLD_LEVEL :
                           statReg.cycleStatusLow;
   assign cycleStatusLowOeN = floatReg ? mmb_pkg::OE_RELEASE : mmb_pkg::OE_DRIVE;

   assign ioMemSel = floatReg ? mmb_pkg::PIN_HOLD_LEVEL : statReg.ioMemSel;
   assign ioMemSelOeN = floatReg ? mmb_pkg::OE_RELEASE : mmb_pkg::OE_DRIVE;

endmodule

// *** shared/mmb_pkg.sv ***
// constants, types and cycle encodings shared by the minimum-mode bus controller
package mmb_pkg;

   // ****************************************************************
   // clock and bus-state timing
   // ****************************************************************
   localparam int CLK_PERIOD_NS = 10;
   // one processor clock state, as printed in ns of the bus model
   localparam int TSTATE_NS = 20;
   // clk cycles per half of a clock state (at least one)
   localparam int HALF_CYCLES_RAW = (TSTATE_NS / 2) / CLK_PERIOD_NS;
   localparam int HALF_CYCLES = (HALF_CYCLES_RAW < 1) ? 1 : HALF_CYCLES_RAW;
   localparam int HALF_CNT_W = 4;
   localparam logic [HALF_CNT_W-1:0] HALF_LAST = HALF_CNT_W'(HALF_CYCLES - 1);
   localparam logic [HALF_CNT_W-1:0] HALF_CNT_RST = 4'h0;

   // ****************************************************************
   // released pin level and reset values
   // ****************************************************************
   localparam logic PIN_HOLD_LEVEL = 1'b1;
   localparam logic OE_DRIVE = 1'b0;
   localparam logic OE_RELEASE = 1'b1;
   localparam logic GRANT_RST = 1'b0;
   localparam logic FLOAT_RST = 1'b0;
   localparam logic XCVR_EN_OFF = 1'b1;
   localparam logic XCVR_EN_ON = 1'b0;
   localparam logic DIR_TRANSMIT = 1'b1;
   localparam logic DIR_RECEIVE = 1'b0;
   localparam logic SEL_IO = 1'b1;
   localparam logic SEL_MEM = 1'b0;

   // ****************************************************************
   // cycle kinds and their status encoding
   // ****************************************************************
   typedef enum logic [2:0]
   {
      MMB_INT_ACK,
      MMB_IO_READ,
      MMB_IO_WRITE,
      MMB_CODE_READ,
      MMB_MEM_READ,
      MMB_MEM_WRITE
   } mmb_cycle_t;

   // select, direction, low status in that order
   typedef struct packed
   {
      logic ioMemSel;
      logic transferDirection;
      logic cycleStatusLow;
   } mmb_status_t;

   localparam mmb_status_t STAT_INT_ACK = 3'h4;
   localparam mmb_status_t STAT_IO_READ = 3'h5;
   localparam mmb_status_t STAT_IO_WRITE = 3'h6;
   localparam mmb_status_t STAT_CODE_READ = 3'h0;
   localparam mmb_status_t STAT_MEM_READ = 3'h1;
   localparam mmb_status_t STAT_MEM_WRITE = 3'h2;
   localparam mmb_status_t STAT_RST = 3'h7;

   // request from the execution side
   typedef struct packed
   {
      logic valid;
      mmb_cycle_t kind;
   } mmb_req_t;

endpackage

// *** sim/mmb_bus_ctrl_asserts.sv ***
// port checker for the bus sequencer
`timescale 1ns/100ps
module mmb_bus_ctrl_asserts
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // cycle side
   input wire mmb_pkg::mmb_req_t cycReq,
   input wire logic cycReqReady,
   input wire logic waitReady,
   input wire logic cycDone,
   // hold side
   input wire logic busReq,
   input wire logic busGrantOut,
   input wire logic busFloat,
   // pins
   input wire logic transferDirection,
   input wire logic transferDirectionOeN,
   input wire logic transceiverEnableN,
   input wire logic transceiverEnableOeN,
   input wire logic cycleStatusLow,
   input wire logic cycleStatusLowOeN,
   input wire logic ioMemSel,
   input wire logic ioMemSelOeN
);
   wire logic [3:0] oeAll;
   wire logic [3:0] pinAll;
   wire logic [2:0] stat;
   assign oeAll = {transferDirectionOeN, transceiverEnableOeN, cycleStatusLowOeN, ioMemSelOeN};
   assign pinAll = {transferDirection, transceiverEnableN, cycleStatusLow, ioMemSel};
   assign stat = {ioMemSel, transferDirection, cycleStatusLow};
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   // ********
   // assertions
   // ********
   float_pins_a: assert property (busFloat |-> (&oeAll) && (&pinAll))
      else $error("pins not released high while floating");
   grant_raise_a: assert property ($rose(busGrantOut) |-> busFloat && $past(busReq, 2))
      else $error("grant raised without float or sampled request");
   grant_drop_a: assert property ($fell(busGrantOut) |-> busFloat && !$past(busReq, 2))
      else $error("grant dropped wrongly");
   take_ok_a: assert property (cycReqReady |-> cycReq.valid && !busGrantOut ##1 !cycReqReady && !busFloat)
      else $error("request taken wrongly");
   enable_window_a: assert property ($fell(transceiverEnableN) |-> !transceiverEnableN [*4])
      else $error("transceiver enable window too short");
   done_enable_a: assert property (cycDone |-> !transceiverEnableN ##1 transceiverEnableN)
      else $error("enable not ended at mid T4");
   idle_enable_a: assert property (cycReqReady && transceiverEnableN |=> transceiverEnableN [*4])
      else $error("enable asserted before T2");
   stat_stable_a: assert property ($fell(transceiverEnableN) |-> $stable(stat) [*3])
      else $error("status changed during transfer");
   grant_seen_c: cover property ($rose(busGrantOut));
   write_done_c: cover property (cycDone && $past(transferDirection));
   wait_done_c: cover property (!waitReady ##1 cycDone);
endmodule

bind mmb_bus_ctrl mmb_bus_ctrl_asserts u_chk
(
   .clk(clk), .rst_n(rst_n), .cycReq(cycReq), .cycReqReady(cycReqReady),
   .waitReady(waitReady), .cycDone(cycDone), .busReq(busReq), .busGrantOut(busGrantOut),
   .busFloat(busFloat), .transferDirection(transferDirection),
   .transferDirectionOeN(transferDirectionOeN), .transceiverEnableN(transceiverEnableN),
   .transceiverEnableOeN(transceiverEnableOeN), .cycleStatusLow(cycleStatusLow),
   .cycleStatusLowOeN(cycleStatusLowOeN), .ioMemSel(ioMemSel), .ioMemSelOeN(ioMemSelOeN)
);

// *** sim/mmb_hold_master.sv ***
// model of another master asking for the local bus
`timescale 1ns/100ps
module mmb_hold_master
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // control from the bench
   input wire logic holdGo,
   input wire logic [7:0] holdLen,
   // hold handshake
   input wire logic busGrantOut,
   output logic busReq
);
   logic [7:0] useCnt;
   // request moves only on the clock and stands for the whole use
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         busReq <= 1'b0;
         useCnt <= 8'h00;
      end
      else if (holdGo)
      begin
         busReq <= 1'b1;
         useCnt <= holdLen;
      end
      else if (busReq && busGrantOut)
      begin
         if (useCnt == 8'h00)
            busReq <= 1'b0;
         else
            useCnt <= useCnt - 8'h01;
      end
   end
endmodule

// *** sim/mmb_bus_ctrl_tb_top.sv ***
// self-checking bench for the bus sequencer and hold handshake
`timescale 1ns/100ps
module mmb_bus_ctrl_tb_top;
   logic clk, rst_n, cycReqReady, waitReady, cycDone, busReq, busGrantOut, busFloat;
   logic dir, dirOe, enN, enOe, stl, stlOe, sel, selOe, holdGo, waitRand;
   mmb_pkg::mmb_req_t cycReq;
   logic [7:0] holdLen;
   int err_count, n_checks;
   logic [2:0] codeTab [6] = '{3'h4, 3'h5, 3'h6, 3'h0, 3'h1, 3'h2};
   mmb_bus_ctrl u_dut
   (
      .clk(clk), .rst_n(rst_n), .cycReq(cycReq), .cycReqReady(cycReqReady),
      .waitReady(waitReady), .cycDone(cycDone), .busReq(busReq), .busGrantOut(busGrantOut),
      .busFloat(busFloat), .transferDirection(dir), .transferDirectionOeN(dirOe),
      .transceiverEnableN(enN), .transceiverEnableOeN(enOe), .cycleStatusLow(stl),
      .cycleStatusLowOeN(stlOe), .ioMemSel(sel), .ioMemSelOeN(selOe)
   );
   mmb_hold_master u_master
   (
      .clk(clk), .rst_n(rst_n), .holdGo(holdGo), .holdLen(holdLen),
      .busGrantOut(busGrantOut), .busReq(busReq)
   );
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk)
      waitReady <= waitRand ? ($urandom % 3 != 0) : 1'b1;
   // ********
   // tasks
   // ********
   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic hung(input int n);
      if (n >= 300)
      begin
         check("wait bound", 8'h01, 8'h00);
         stop_test();
      end
   endtask
   task automatic fire_hold;
      fork
         begin
            @(posedge clk) holdGo <= 1'b1;
            @(posedge clk) holdGo <= 1'b0;
         end
      join_none
   endtask
   task automatic wait_grant(input logic lvl);
      int n;
      n = 0;
      while (busGrantOut !== lvl && n < 300)
      begin
         @(negedge clk);
         n++;
      end
      hung(n);
   endtask
   task automatic run_cycle(input int kind, input int holdAt);
      int k, lowCnt, firstLow, base;
      logic wr;
      wr = (kind == 2 || kind == 5);
      base = wr ? 5 : 4;
      lowCnt = 0;
      firstLow = 0;
      k = 0;
      @(posedge clk) cycReq <= '{valid: 1'b1, kind: mmb_pkg::mmb_cycle_t'(kind)};
      do
      begin
         @(negedge clk);
         k++;
      end
      while (cycReqReady !== 1'b1 && k < 300);
      hung(k);
      @(posedge clk) cycReq.valid <= 1'b0;
      k = 0;
      do
      begin
         @(negedge clk);
         k++;
         if (k == holdAt)
            fire_hold();
         if (cycDone !== 1'b1)
         begin
            check("status", 8'({sel, dir, stl}), 8'(codeTab[kind]));
            check("drive", 8'({selOe, dirOe, stlOe, enOe}), 8'h00);
         end
         if (enN === 1'b0)
         begin
            firstLow = (firstLow == 0) ? k : firstLow;
            lowCnt++;
            check("grant", 8'(busGrantOut), 8'h00);
         end
      end
      while (cycDone !== 1'b1 && k < 300);
      hung(k);
      check("enable first", 8'(firstLow), wr ? 8'h05 : 8'h06);
      check("enable at done", 8'(enN), 8'h00);
      check("done slot", 8'(k), 8'(firstLow + lowCnt - 1));
      check("wait slots", 8'(lowCnt >= base && (lowCnt - base) % 2 == 0), 8'h01);
   endtask
   // ********
   // main sequence
   // ********
   initial
   begin
      int k, takes, lastTake;
      rst_n = 1'b0;
      cycReq = '0;
      waitRand = 1'b0;
      holdGo = 1'b0;
      holdLen = 8'h00;
      err_count = 0;
      n_checks = 0;
      void'($urandom(19654));
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 6; i++)
         run_cycle(i, 0);
      $display("test kinds done");
      waitRand <= 1'b1;
      repeat (8) run_cycle($urandom % 6, 0);
      waitRand <= 1'b0;
      $display("test waits done");
      holdLen <= 8'(10 + $urandom % 20);
      fire_hold();
      wait_grant(1'b1);
      check("float pins", {dirOe, enOe, stlOe, selOe, dir, enN, stl, sel}, 8'hff);
      @(posedge clk) cycReq <= '{valid: 1'b1, kind: mmb_pkg::MMB_MEM_READ};
      repeat (3) @(negedge clk) check("refused", 8'(cycReqReady), 8'h00);
      @(posedge clk) cycReq.valid <= 1'b0;
      wait_grant(1'b0);
      check("float after drop", 8'(busFloat), 8'h01);
      run_cycle(4, 0);
      $display("test hold idle done");
      run_cycle(1, 3);
      wait_grant(1'b1);
      wait_grant(1'b0);
      run_cycle(5, 0);
      $display("test hold in cycle done");
      @(posedge clk) cycReq <= '{valid: 1'b1, kind: mmb_pkg::MMB_MEM_WRITE};
      k = 0;
      takes = 0;
      lastTake = 0;
      while (takes < 3 && k < 300)
      begin
         @(negedge clk);
         k++;
         if (cycReqReady === 1'b1)
         begin
            if (takes > 0)
               check("take gap", 8'(k - lastTake), 8'h08);
            lastTake = k;
            takes++;
         end
      end
      hung(k);
      @(posedge clk) cycReq.valid <= 1'b0;
      repeat (12) @(posedge clk);
      $display("test back to back done");
      stop_test();
   end
endmodule
